// ---- rtl/pmc_parser.sv ----
/*
 * In-band command parser for one switch input port; one instance per
 * input keeps every port independent.
 * Assumes the byte stream and buffer-full flag come from logic on clk_in
 * and that the downstream buffer never stalls the data output.
 */
// Behaviour
// RULE_01: Frame opens with command_prefix, closes with bracket
// RULE_02: Any mismatching character means not a command
// RULE_03: Exactly one space, tab, LF or FF separates
// RULE_04: After reset everything routes to port 1
// RULE_05: Destination port must be 1 to 12
// RULE_06: New route applies to later data only
// RULE_07: Optional colon copy count up to 255
// RULE_08: Extra copies wait for timeout or end-of-file
// RULE_09: Buffer overflow limits output to one copy
// RULE_10: Idle timeout defaults to 16 seconds
// RULE_11: Up to four destinations share the data
// RULE_12: Output stays reserved for timeout after idle
// RULE_13: Timeout off holds reservation until command
// RULE_14: Timeout value 1 to 255 or OFF only
// RULE_15: Timeout setting persists until changed
// RULE_16: Sleep passes commands as data until timeout
// RULE_17: Enable option restores normal interpretation
// RULE_18: Disable option stops interpretation until reset
// RULE_19: Ignore option drops CR, LF or CR-LF
// RULE_20: Clear drops only this port's pending data
// RULE_21: End-of-file ends file and releases output
// RULE_22: Any new command ends the current file
// RULE_23: Failed candidate bytes forwarded in order
// RULE_24: Each input port keeps its own state
`include "pmc_cfg.svh"

module pmc_parser #(
  parameter int CYC_PER_SEC = `PMC_CLK_HZ * `PMC_TICK_S
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        in_valid_in,
  input  wire logic [7:0]  in_data_in,
  output logic             in_ready_out,
  input  wire logic        buf_over_in,
  output logic             out_valid_out,
  output logic [7:0]       out_data_out,
  output logic [15:0]      dest_list_out,
  output logic [2:0]       dest_cnt_out,
  output logic [31:0]      copies_out,
  output logic             reserve_out,
  output logic             file_end_out,
  output logic             clear_out,
  output logic [1:0]       mode_out,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out
);
  localparam logic [31:0] SEC_LAST = 32'(CYC_PER_SEC - 1);

  function automatic logic pmc_is_sep(input logic [7:0] c);
    return c == `PMC_CH_SP || c == `PMC_CH_TAB ||
           c == `PMC_CH_LF || c == `PMC_CH_FF;
  endfunction

  function automatic logic pmc_is_dig(input logic [7:0] c);
    return c >= `PMC_CH_D0 && c <= `PMC_CH_D9;
  endfunction

  // Saturates at the overflow mark so long digit runs stay invalid
  function automatic logic [8:0] pmc_dec(input logic [8:0] n,
                                         input logic [7:0] c);
    logic [12:0] t;
    t = 13'({4'h0, n} * `PMC_NUM_TEN) + 13'(c - `PMC_CH_D0);
    if (n >= `PMC_NUM_OVF || t >= 13'(`PMC_NUM_OVF))
      return `PMC_NUM_OVF;
    return t[8:0];
  endfunction

  // RULE_24 per-port state
  pmc_pkg::pmc_state_t st_q, st_d;
  pmc_pkg::pmc_mode_t  mode_q;
  pmc_pkg::pmc_phase_t ph_q;
  logic [7:0]  mem [0:47];
  logic [5:0]  cn_q, rp_q;
  logic        rdy_q, scr_q, cmt_q;
  logic [79:0] head_q, tail_q;
  logic [3:0]  hlen_q, tlen_q;
  logic [8:0]  hnum_q, tnum_q;
  logic        hdig_q, tdig_q, colon_q, tbad_q;
  logic [15:0] sdest_q, dest_q;
  logic [31:0] scop_q, cop_q, cop_out_q;
  logic [2:0]  sn_q, dcnt_q;
  logic        sopt_q, sto_set_q, smode_set_q, sign_q;
  logic        sclr_q;
  logic [7:0]  sto_q, hold_q, idle_q;
  pmc_pkg::pmc_mode_t smode_q;
  logic [31:0] sec_q, rsel, rdata_q;
  logic        resv_q, fend_q, clr_q, ovf_q;
  logic        oval_q;
  logic [7:0]  odat_q;

  // ------------------------------------------------------------
  // Character classes and events
  // ------------------------------------------------------------
  wire [7:0] ch     = in_data_in;
  wire       acc    = in_valid_in & rdy_q;
  wire       sep    = pmc_is_sep(ch);
  wire       gt     = ch == `PMC_CH_GT;
  wire       in_cnd = st_q == pmc_pkg::HEAD || st_q == pmc_pkg::SEP ||
                      st_q == pmc_pkg::TOK;
  wire       drop   = st_q == pmc_pkg::SKIP &&
                      (ch == `PMC_CH_LF || (ch == `PMC_CH_CR && !scr_q));
  wire       idl    = st_q == pmc_pkg::IDLE ||
                      (st_q == pmc_pkg::SKIP && !drop);
  wire       start  = acc && idl && mode_q == pmc_pkg::NORM &&
                      ch == `PMC_CH_LT;
  wire       pass   = acc && idl && !start;
  wire       hd_bad = st_q == pmc_pkg::HEAD &&
                      ((cn_q == 6'h01 && ch != `PMC_CH_P) ||
                       (cn_q == 6'h02 && ch != `PMC_CH_M) ||
                       (cn_q == `PMC_PFX_LEN && !sep));
  wire       tend   = acc && st_q == pmc_pkg::TOK && (sep || gt);
  wire       app    = acc && !sep && !gt &&
                      (st_q == pmc_pkg::SEP || st_q == pmc_pkg::TOK);

  // ------------------------------------------------------------
  // Token classification
  // ------------------------------------------------------------
  wire is_conn = !colon_q && head_q == `PMC_KW_CONNECT;
  wire is_clr  = !colon_q && head_q == `PMC_KW_CLEAR;
  wire is_eof  = !colon_q && head_q == `PMC_KW_EOF;
  wire t_off   = tail_q == `PMC_KW_OFF;
  wire t_num   = tdig_q && tnum_q != 9'h000 && tnum_q < `PMC_NUM_OVF;
  wire port_ok = hdig_q && hnum_q != 9'h000 &&
                 hnum_q <= `PMC_PORT_MAX && (!colon_q || t_num) &&
                 sn_q < `PMC_DEST_MAX && !sopt_q;
  wire to_ok   = colon_q && head_q == `PMC_KW_TIMEOUT &&
                 (t_num || t_off);
  wire sw_slp  = tail_q == `PMC_KW_SLEEP;
  wire sw_ena  = tail_q == `PMC_KW_ENABLE;
  wire sw_dis  = tail_q == `PMC_KW_DISABLE;
  wire sw_ok   = colon_q && head_q == `PMC_KW_SOFTWARE &&
                 (sw_slp || sw_ena || sw_dis);
  wire ig_ok   = !colon_q && head_q == `PMC_KW_IGNORE;
  wire opt_ok  = sn_q != 3'h0 && (to_ok || sw_ok || ig_ok);
  wire tok_ok  = !tbad_q &&
                 (ph_q == pmc_pkg::PH_CMD ? (is_conn || is_clr || is_eof)
                  : ph_q == pmc_pkg::PH_CONN && (port_ok || opt_ok));
  wire fin_ok  = tok_ok && !(ph_q == pmc_pkg::PH_CMD && is_conn);

  // RULE_01 RULE_02 RULE_03 any mismatch aborts the candidate
  wire fail = acc && in_cnd &&
              (hd_bad || (st_q == pmc_pkg::SEP && (sep || gt)) ||
               (tend && !tok_ok) || (tend && gt && !fin_ok) ||
               cn_q == `PMC_CAND_LAST);
  wire fin  = tend && gt && !fail;

  // ------------------------------------------------------------
  // Idle timer
  // ------------------------------------------------------------
  wire tick   = sec_q == SEC_LAST;
  wire active = resv_q || mode_q == pmc_pkg::SLEEP;
  // RULE_12 RULE_13 zero hold means no expiry
  wire expire = tick && active && hold_q != 8'h00 &&
                8'(idle_q + 8'h01) == hold_q;
  wire fe     = cmt_q || expire;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (fail) begin
      st_d = pmc_pkg::RPLY;
    end else begin
      case (st_q)
        pmc_pkg::IDLE: begin
          // RULE_19 line end dropping after the terminator
          if (cmt_q && sign_q)
            st_d = pmc_pkg::SKIP;
          else if (start)
            st_d = pmc_pkg::HEAD;
        end
        pmc_pkg::SKIP: begin
          if (start)
            st_d = pmc_pkg::HEAD;
          else if (acc)
            st_d = (drop && ch == `PMC_CH_CR) ? pmc_pkg::SKIP
                                               : pmc_pkg::IDLE;
        end
        pmc_pkg::HEAD: begin
          if (acc && cn_q == `PMC_PFX_LEN)
            st_d = pmc_pkg::SEP;
        end
        pmc_pkg::SEP: begin
          if (acc)
            st_d = pmc_pkg::TOK;
        end
        pmc_pkg::TOK: begin
          if (tend)
            st_d = gt ? pmc_pkg::IDLE : pmc_pkg::SEP;
        end
        pmc_pkg::RPLY: begin
          if (6'(rp_q + 6'h01) == cn_q)
            st_d = pmc_pkg::IDLE;
        end
        default: st_d = pmc_pkg::IDLE;
      endcase
    end
  end

  // Input stalls for replay and for the commit cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q  <= pmc_pkg::IDLE;
      rdy_q <= 1'b0;
      scr_q <= 1'b0;
      cmt_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      rdy_q <= st_d != pmc_pkg::RPLY && !fin;
      scr_q <= st_q == pmc_pkg::SKIP && st_d == pmc_pkg::SKIP;
      cmt_q <= fin;
    end
  end

  // ------------------------------------------------------------
  // Candidate store and replay
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (start || (acc && in_cnd))
      mem[start ? 6'h00 : cn_q] <= ch;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cn_q <= 6'h00;
      rp_q <= 6'h00;
    end else begin
      if (start)
        cn_q <= 6'h01;
      else if (acc && in_cnd)
        cn_q <= 6'(cn_q + 6'h01);
      rp_q <= st_q == pmc_pkg::RPLY ? 6'(rp_q + 6'h01) : 6'h00;
    end
  end

  // RULE_23 failed bytes leave in arrival order
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oval_q <= 1'b0;
      odat_q <= 8'h00;
    end else begin
      oval_q <= pass || st_q == pmc_pkg::RPLY;
      odat_q <= pass ? ch : mem[rp_q];
    end
  end

  // ------------------------------------------------------------
  // Token collector
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {head_q, tail_q, hlen_q, tlen_q} <= '0;
      {hnum_q, tnum_q, hdig_q, tdig_q, colon_q, tbad_q} <= '0;
    end else if (start || tend) begin
      {head_q, tail_q, hlen_q, tlen_q} <= '0;
      {hnum_q, tnum_q, hdig_q, tdig_q, colon_q, tbad_q} <= '0;
    end else if (app) begin
      if (ch == `PMC_CH_COLON) begin
        colon_q <= 1'b1;
        if (colon_q)
          tbad_q <= 1'b1;
      end else if (!colon_q) begin
        head_q <= {head_q[71:0], ch};
        hlen_q <= 4'(hlen_q + 4'h1);
        hdig_q <= (hlen_q == 4'h0 || hdig_q) && pmc_is_dig(ch);
        hnum_q <= pmc_dec(hnum_q, ch);
        if (hlen_q == `PMC_TOK_MAX)
          tbad_q <= 1'b1;
      end else begin
        tail_q <= {tail_q[71:0], ch};
        tlen_q <= 4'(tlen_q + 4'h1);
        tdig_q <= (tlen_q == 4'h0 || tdig_q) && pmc_is_dig(ch);
        tnum_q <= pmc_dec(tnum_q, ch);
        if (tlen_q == `PMC_TOK_MAX)
          tbad_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Staged command
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {sdest_q, scop_q, sn_q, sopt_q, sto_q} <= '0;
      {sto_set_q, smode_set_q, sign_q, sclr_q} <= '0;
      smode_q <= pmc_pkg::NORM;
      ph_q    <= pmc_pkg::PH_CMD;
    end else if (start) begin
      {sdest_q, scop_q, sn_q, sopt_q, sto_q} <= '0;
      {sto_set_q, smode_set_q, sign_q, sclr_q} <= '0;
      ph_q <= pmc_pkg::PH_CMD;
    end else if (tend && tok_ok) begin
      if (ph_q == pmc_pkg::PH_CMD) begin
        ph_q   <= is_conn ? pmc_pkg::PH_CONN : pmc_pkg::PH_DONE;
        sclr_q <= is_clr;
      end else if (port_ok) begin
        // RULE_05 RULE_07 RULE_11 port and copy count
        sdest_q[4 * sn_q +: 4] <= hnum_q[3:0];
        scop_q[8 * sn_q +: 8]  <= colon_q ? tnum_q[7:0] : `PMC_ONE_COPY;
        sn_q <= 3'(sn_q + 3'h1);
      end else begin
        sopt_q <= 1'b1;
        // RULE_14 value or OFF, zero stands for OFF
        if (to_ok) begin
          sto_set_q <= 1'b1;
          sto_q     <= t_off ? 8'h00 : tnum_q[7:0];
        end
        // RULE_16 RULE_17 RULE_18 interpretation modes
        if (sw_ok) begin
          smode_set_q <= 1'b1;
          smode_q <= sw_slp ? pmc_pkg::SLEEP :
                     sw_dis ? pmc_pkg::OFF : pmc_pkg::NORM;
        end
        if (ig_ok)
          sign_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Live settings
  // ------------------------------------------------------------
  // RULE_04 RULE_10 reset route and hold time
  // RULE_06 RULE_15 settings change on commit; hold also by register write, sleep also ends on expiry
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dest_q <= 16'h0001;
      cop_q  <= 32'h0000_0001;
      dcnt_q <= 3'h1;
      hold_q <= `PMC_HOLD_DEF;
      mode_q <= pmc_pkg::NORM;
    end else begin
      if (cmt_q && sn_q != 3'h0) begin
        dest_q <= sdest_q;
        cop_q  <= scop_q;
        dcnt_q <= sn_q;
      end
      if (cmt_q && sto_set_q)
        hold_q <= sto_q;
      else if (reg_wr_in && reg_addr_in == `PMC_REG_HOLD)
        hold_q <= reg_wdata_in[7:0];
      // RULE_18 off is never left before reset
      if (mode_q != pmc_pkg::OFF) begin
        if (cmt_q && smode_set_q)
          mode_q <= smode_q;
        else if (expire && mode_q == pmc_pkg::SLEEP)
          mode_q <= pmc_pkg::NORM;
      end
    end
  end

  // RULE_08 RULE_21 RULE_22 file end and release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_q  <= 32'h0;
      idle_q <= 8'h00;
      resv_q <= 1'b0;
      fend_q <= 1'b0;
      clr_q  <= 1'b0;
      ovf_q  <= 1'b0;
    end else begin
      sec_q  <= (acc || tick) ? 32'h0 : 32'(sec_q + 32'h1);
      idle_q <= (acc || expire) ? 8'h00 :
                tick ? 8'(idle_q + 8'h01) : idle_q;
      resv_q <= oval_q || (resv_q && !fe);
      fend_q <= fe;
      // RULE_20 clear pulse for this port only
      clr_q  <= cmt_q && sclr_q;
      ovf_q  <= buf_over_in || (ovf_q && !fe);
    end
  end

  // RULE_09 overflow caps each lane at one copy
  for (genvar i = 0; i < 4; i++) begin : g_lane
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
        cop_out_q[8 * i +: 8] <= 8'h00;
      else if (ovf_q && cop_q[8 * i +: 8] != 8'h00)
        cop_out_q[8 * i +: 8] <= `PMC_ONE_COPY;
      else
        cop_out_q[8 * i +: 8] <= cop_q[8 * i +: 8];
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_comb begin
    if (reg_addr_in == `PMC_REG_HOLD)
      rsel = {24'h0, hold_q};
    else if (reg_addr_in == `PMC_REG_STAT)
      rsel = {22'h0, dcnt_q, ovf_q, resv_q, st_q, mode_q};
    else if (reg_addr_in == `PMC_REG_ROUTE)
      rsel = {16'h0, dest_q};
    else if (reg_addr_in == `PMC_REG_COPY)
      rsel = cop_q;
    else
      rsel = 32'h0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rdata_q <= 32'h0;
    else
      rdata_q <= reg_rd_in ? rsel : 32'h0;
  end

  assign in_ready_out  = rdy_q;
  assign out_valid_out = oval_q;
  assign out_data_out  = odat_q;
  assign dest_list_out = dest_q;
  assign dest_cnt_out  = dcnt_q;
  assign copies_out    = cop_out_q;
  assign reserve_out   = resv_q;
  assign file_end_out  = fend_q;
  assign clear_out     = clr_q;
  assign mode_out      = mode_q;
  assign reg_rdata_out = rdata_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_fail3;
    fail && cn_q == 6'h02;
  endsequence
  sequence s_out3;
    out_valid_out [*3];
  endsequence

  prefix_check_a: assert property ( // RULE_01
    acc && st_q == pmc_pkg::HEAD && cn_q == 6'h01 && ch != `PMC_CH_P
    |=> st_q == pmc_pkg::RPLY) else $error("bad prefix kept");
  double_sep_a: assert property ( // RULE_03
    acc && st_q == pmc_pkg::SEP && sep |=> st_q == pmc_pkg::RPLY)
    else $error("double separator accepted");
  port_range_a: assert property ( // RULE_05
    tend && ph_q == pmc_pkg::PH_CONN && hdig_q &&
    hnum_q > `PMC_PORT_MAX |=> st_q == pmc_pkg::RPLY)
    else $error("port above range accepted");
  route_hold_a: assert property ( // RULE_06
    !cmt_q |=> $stable(dest_list_out))
    else $error("route changed without command");
  ovf_clamp_a: assert property ( // RULE_09
    ovf_q |=> copies_out[7:0] <= `PMC_ONE_COPY)
    else $error("copies not capped");
  idle_release_a: assert property ( // RULE_12
    expire |=> file_end_out ##1 !reserve_out)
    else $error("timeout did not release");
  hold_off_a: assert property ( // RULE_13
    reserve_out && hold_q == 8'h00 && !cmt_q |=> reserve_out)
    else $error("reservation lost with timeout off");
  sleep_pass_a: assert property ( // RULE_16
    acc && mode_q == pmc_pkg::SLEEP |=> out_valid_out)
    else $error("sleep byte not passed");
  off_pass_a: assert property ( // RULE_18
    acc && mode_q == pmc_pkg::OFF
    |=> out_valid_out && out_data_out == $past(in_data_in))
    else $error("byte interpreted while off");
  ignore_lf_a: assert property ( // RULE_19
    acc && st_q == pmc_pkg::SKIP && ch == `PMC_CH_LF |=> !out_valid_out)
    else $error("line feed not dropped");
  clear_pulse_a: assert property ( // RULE_20
    cmt_q && sclr_q |=> clear_out && file_end_out)
    else $error("clear not signalled");
  replay_len_a: assert property ( // RULE_23
    s_fail3 |=> ##1 s_out3 ##1 !out_valid_out)
    else $error("replay length wrong");
endmodule

// ---- rtl/pmc_cfg.svh ----
/*
 * Constants of the in-band command parser: characters, keywords,
 * limits, register offsets and timing.
 * Assumes 8-bit ASCII input and a 50 MHz system clock.
 */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_CH_LT     8'h3c
`define PMC_CH_GT     8'h3e
`define PMC_CH_P      8'h50
`define PMC_CH_M      8'h4d
`define PMC_CH_COLON  8'h3a
`define PMC_CH_SP     8'h20
`define PMC_CH_TAB    8'h09
`define PMC_CH_LF     8'h0a
`define PMC_CH_FF     8'h0c
`define PMC_CH_CR     8'h0d
`define PMC_CH_D0     8'h30
`define PMC_CH_D9     8'h39

`define PMC_KW_CONNECT  80'h434f4e4e454354
`define PMC_KW_CLEAR    80'h434c454152
`define PMC_KW_EOF      80'h454f46
`define PMC_KW_TIMEOUT  80'h54494d454f5554
`define PMC_KW_SOFTWARE 80'h534f465457415245
`define PMC_KW_SLEEP    80'h534c454550
`define PMC_KW_ENABLE   80'h454e41424c45
`define PMC_KW_DISABLE  80'h44495341424c45
`define PMC_KW_IGNORE   80'h49474e4f5245
`define PMC_KW_OFF      80'h4f4646

`define PMC_TOK_MAX   4'ha
`define PMC_NUM_OVF   9'h100
`define PMC_NUM_TEN   13'h00a
`define PMC_PORT_MAX  9'h00c
`define PMC_DEST_MAX  3'h4
`define PMC_PFX_LEN   6'h03
`define PMC_CAND_LAST 6'h2f
`define PMC_HOLD_DEF  8'h10
`define PMC_ONE_COPY  8'h01

`define PMC_REG_HOLD  4'h0
`define PMC_REG_STAT  4'h4
`define PMC_REG_ROUTE 4'h8
`define PMC_REG_COPY  4'hc

`define PMC_CLK_HZ    50000000
`define PMC_TICK_S    1

`endif

// ---- rtl/pmc_pkg.sv ----
/*
 * Types of the in-band command parser.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmc_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'h0,
    HEAD = 3'h1,
    SEP  = 3'h3,
    TOK  = 3'h2,
    SKIP = 3'h6,
    RPLY = 3'h7
  } pmc_state_t;

  typedef enum logic [1:0] {
    NORM  = 2'h0,
    SLEEP = 2'h1,
    OFF   = 2'h3
  } pmc_mode_t;

  typedef enum logic [1:0] {
    PH_CMD  = 2'h0,
    PH_CONN = 2'h1,
    PH_DONE = 2'h3
  } pmc_phase_t;
endpackage

// ---- verif/pmc_host.sv ----
/*
 * Host model: feeds one parser input port, byte by byte.
 * Assumes the parser's registered ready flag on clk_in.
 */
module pmc_host (
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  output logic            valid_out,
  output logic [7:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_stall = 0;
  initial begin
    valid_out = 1'b0;
    data_out  = 8'h00;
  end
  task automatic send(input string s);
    logic ok;
    int   k;
    for (int i = 0; i < s.len(); i++) begin
      valid_out <= 1'b1;
      data_out  <= s[i];
      k = 0;
      do begin
        @(negedge clk_in);
        ok = (ready_in === 1'b1);
        @(posedge clk_in);
        k++;
      end while (!ok && k < 200);
      if (!ok) n_stall++;
    end
    valid_out <= 1'b0;
    // Released line must not echo the last byte
    data_out  <= ~data_out;
  endtask
endmodule

// ---- verif/inband_port_switch_command_parser_bench.sv ----
/*
 * Self-checking bench of one parser input port.
 * Assumes pmc_cfg.svh on the include path and the host model.
 */
`include "pmc_cfg.svh"
module inband_port_switch_command_parser_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        buf_over_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        v, in_ready_out, out_valid_out, reserve_out;
  logic        file_end_out, clear_out;
  logic [7:0]  b, out_data_out;
  logic [15:0] dest_list_out;
  logic [2:0]  dest_cnt_out;
  logic [31:0] copies_out, reg_rdata_out, d;
  logic [1:0]  mode_out;
  logic [7:0]  outq[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_end = 0;
  int          n_clr = 0;
  int          k;
  string       bad[6] = '{"<PMx", "<PM CONNECT 13>", "<PM CONNECT  2>",
                          "<PM CONNECT 2 TIMEOUT:256>", "<Px", "<Q"};

  initial forever #10 clk_in = ~clk_in;

  pmc_host host (.clk_in(clk_in), .ready_in(in_ready_out),
                 .valid_out(v), .data_out(b));
  pmc_parser #(.CYC_PER_SEC(20)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .in_valid_in(v),
    .in_data_in(b), .in_ready_out(in_ready_out),
    .buf_over_in(buf_over_in), .out_valid_out(out_valid_out),
    .out_data_out(out_data_out), .dest_list_out(dest_list_out),
    .dest_cnt_out(dest_cnt_out), .copies_out(copies_out),
    .reserve_out(reserve_out), .file_end_out(file_end_out),
    .clear_out(clear_out), .mode_out(mode_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));

  // Registered outputs sampled mid-cycle to stay clear of edge races
  always @(negedge clk_in) begin
    if (out_valid_out === 1'b1) outq.push_back(out_data_out);
    if (file_end_out === 1'b1) n_end++;
    if (clear_out === 1'b1) n_clr++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    n_mismatch += host.n_stall;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input string s);
    chk(32'(outq.size()), 32'(s.len()));
    for (int i = 0; i < s.len() && i < outq.size(); i++)
      chk(32'(outq[i]), 32'(s[i]));
    outq.delete();
  endtask
  task automatic bound(input int n);
    if (k >= n) begin
      n_mismatch++;
      results();
    end
  endtask
  // Quiet means ready up and no output valid for four cycles
  task automatic settle;
    int q = 0;
    k = 0;
    while (q < 4 && k < 200) begin
      @(negedge clk_in);
      k++;
      q = (in_ready_out === 1'b1 && out_valid_out !== 1'b1) ? q + 1 : 0;
    end
    bound(200);
    @(posedge clk_in);
  endtask
  task automatic tx(input string s);
    host.send(s);
    settle();
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    r = reg_rdata_out;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    settle();
    chk(32'(dest_list_out), 32'h0001);
    chk(32'(dest_cnt_out), 32'h1);
    chk(copies_out, 32'h1);
    rd(`PMC_REG_HOLD, d);
    chk(d, 32'h10);
    rd(`PMC_REG_STAT, d);
    chk(d, 32'h80);
    rd(4'h2, d);
    chk(d, 32'h0);
    tx("ab");
    chk_out("ab");
    n_end = 0;
    tx("<PM CONNECT 3:2 1>");
    chk_out("");
    chk(32'(dest_list_out), 32'h0013);
    chk(32'(dest_cnt_out), 32'h2);
    chk(copies_out, 32'h0102);
    chk(32'(n_end), 32'h1);
    rd(`PMC_REG_ROUTE, d);
    chk(d, 32'h0013);
    buf_over_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(copies_out, 32'h0101);
    buf_over_in <= 1'b0;
    rd(`PMC_REG_COPY, d);
    chk(d, 32'h0102);
    foreach (bad[i]) begin
      tx(bad[i]);
      chk_out(bad[i]);
    end
    chk(32'(dest_list_out), 32'h0013);
    rd(`PMC_REG_HOLD, d);
    chk(d, 32'h10);
    tx("<PM CONNECT 2 TIMEOUT:5>");
    rd(`PMC_REG_HOLD, d);
    chk(d, 32'h5);
    chk(32'(dest_list_out), 32'h0002);
    wr(`PMC_REG_HOLD, 32'h3);
    rd(`PMC_REG_HOLD, d);
    chk(d, 32'h3);
    tx("z");
    chk(32'(reserve_out), 32'h1);
    repeat (40) @(posedge clk_in);
    chk(32'(reserve_out), 32'h1);
    k = 0;
    while (reserve_out !== 1'b0 && k < 40) begin
      @(posedge clk_in);
      k++;
    end
    bound(40);
    tx("<PM CONNECT 2 TIMEOUT:OFF>");
    rd(`PMC_REG_HOLD, d);
    chk(d, 32'h0);
    outq.delete();
    tx("q");
    repeat (80) @(posedge clk_in);
    chk(32'(reserve_out), 32'h1);
    n_end = 0;
    tx("<PM EOF>");
    chk(32'(reserve_out), 32'h0);
    chk(32'(n_end), 32'h1);
    wr(`PMC_REG_HOLD, 32'h3);
    outq.delete();
    tx("<PM CONNECT 4 IGNORE>\015\012k");
    chk_out("k");
    n_clr = 0;
    tx("<PM CLEAR>");
    chk(32'(n_clr), 32'h1);
    tx("<PM CONNECT 2 SOFTWARE:SLEEP>");
    chk(32'(mode_out), 32'h1);
    tx("<PM EOF>");
    chk_out("<PM EOF>");
    k = 0;
    while (mode_out !== 2'h0 && k < 100) begin
      @(posedge clk_in);
      k++;
    end
    bound(100);
    tx("<PM CONNECT 2 SOFTWARE:ENABLE>");
    chk_out("");
    chk(32'(mode_out), 32'h0);
    tx("<PM CONNECT 5 SOFTWARE:DISABLE>");
    chk(32'(mode_out), 32'h3);
    tx("<PM CLEAR>");
    chk_out("<PM CLEAR>");
    results();
  end
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
endmodule
